// ===== cta_datapath.sv
// Transfer and arithmetic datapath with Wishbone command port
// Behaviour
// - Registers read as 16 bytes, 16 words (low and upper) or 8 longs.
// - Move works at byte, word, long: reg-reg, reg-memory, immediate.
// - Synchronous peripheral moves are refused as illegal commands.
// - Pop reads at stack pointer, then increments the pointer.
// - Push decrements the stack pointer first, then writes there.
// - Add and subtract at any size on registers or immediate.
// - Plain subtract of a byte immediate is refused.
// - Carry add and borrow subtract are byte only and use carry.
// - Increment/decrement by 1 or 2; bytes by 1 only.
// - Small-constant long add/subtract uses 1, 2 or 4 on longs.
// - Decimal adjust corrects a byte to packed BCD using the flags.
// - Unsigned multiply: 8x8 to 16 bits, 16x16 to 32 bits.
// - Signed multiply: 8x8 to 16 bits, 16x16 to 32 bits.
// - Flags register holds N, Z, V, C for arithmetic and readers.
`timescale 1ns/1ns
`include "cta_defines.svh"
module cta_datapath (
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	output logic             MEM_REQ,
	output logic             MEM_WE,
	output logic      [1:0]  MEM_SIZE,
	output logic      [31:0] MEM_ADDR,
	output logic      [31:0] MEM_WDATA,
	input  wire logic [31:0] MEM_RDATA,
	input  wire logic        MEM_ACK
);
	import cta_pkg::*;

	logic [31:0] gr [8];
	logic [31:0] imm;
	logic [3:0]  condition_flags_register;
	logic        stat_ill;
	cta_state_e  state;
	logic [3:0]  pend_dst;
	cta_size_e   pend_sz;
	logic        pend_pop;
	logic        wb_req;
	logic        wr_now;
	logic        exec_go;
	logic        win_wr;
	logic        mem_done;
	cta_op_e     op;
	cta_size_e   sz;
	logic [3:0]  dst;
	logic [3:0]  src;
	logic [31:0] a;
	logic [31:0] b;
	logic [31:0] stp;
	logic [35:0] ar;
	logic        next_ok;
	logic        next_wr;
	cta_size_e   next_wsz;
	logic [3:0]  next_widx;
	logic [31:0] next_val;
	logic [3:0]  next_ccr;
	logic        next_mem;
	logic        next_mwe;
	logic [31:0] next_maddr;
	logic [31:0] next_mdata;
	logic        next_pop;
	logic [7:0]  adj;
	logic [15:0] prod8;
	logic [31:0] prod16;

	function automatic logic [31:0] mask_sz(input logic [31:0] v,
		input cta_size_e s);
		unique case (s)
			SZ_BYTE: mask_sz = {24'h000000, v[7:0]};
			SZ_WORD: mask_sz = {16'h0000, v[15:0]};
			// The unused size code falls back to the full 32 bits
			default: mask_sz = v;
		endcase
	endfunction : mask_sz

	function automatic logic msb_of(input logic [31:0] v, input cta_size_e s);
		unique case (s)
			SZ_BYTE: msb_of = v[7];
			SZ_WORD: msb_of = v[15];
			default: msb_of = v[31];
		endcase
	endfunction : msb_of

	function automatic logic [31:0] size_bytes(input cta_size_e s);
		unique case (s)
			SZ_BYTE: size_bytes = `CTA_ONE32;
			SZ_WORD: size_bytes = `CTA_TWO32;
			default: size_bytes = `CTA_FOUR32;
		endcase
	endfunction : size_bytes

	// Byte idx[3]=1 picks the low byte; word idx[3]=1 picks the upper half
	function automatic logic [31:0] get_op(input logic [3:0] idx,
		input cta_size_e s);
		logic [31:0] r;
		r = gr[idx[2:0]];
		unique case (s)
			SZ_BYTE: get_op = idx[3] ? {24'h000000, r[7:0]}
				: {24'h000000, r[15:8]};
			SZ_WORD: get_op = idx[3] ? {16'h0000, r[31:16]}
				: {16'h0000, r[15:0]};
			default: get_op = r;
		endcase
	endfunction : get_op

	function automatic logic [31:0] put_op(input logic [31:0] old,
		input logic [3:0] idx, input cta_size_e s, input logic [31:0] v);
		unique case (s)
			SZ_BYTE: put_op = idx[3] ? {old[31:8], v[7:0]}
				: {old[31:16], v[7:0], old[7:0]};
			SZ_WORD: put_op = idx[3] ? {v[15:0], old[15:0]}
				: {old[31:16], v[15:0]};
			default: put_op = v;
		endcase
	endfunction : put_op

	// Returns {flags, result}; operands arrive masked to the size
	function automatic logic [35:0] addsub(input logic [31:0] x,
		input logic [31:0] y, input logic cin, input logic sub,
		input cta_size_e s);
		logic [32:0] t;
		logic [31:0] r;
		logic [3:0]  f;
		t = sub ? {1'b0, x} - {1'b0, y} - {32'h0, cin}
			: {1'b0, x} + {1'b0, y} + {32'h0, cin};
		r = mask_sz(t[31:0], s);
		f[`CTA_FL_N] = msb_of(r, s);
		f[`CTA_FL_Z] = (r == `CTA_ZERO32);
		f[`CTA_FL_C] = (s == SZ_LONG) ? t[32] : (s == SZ_WORD) ? t[16]
			: t[8];
		f[`CTA_FL_V] = (sub ? (msb_of(x, s) != msb_of(y, s))
			: (msb_of(x, s) == msb_of(y, s)))
			&& (msb_of(r, s) != msb_of(x, s));
		addsub = {f, r};
	endfunction : addsub

	function automatic logic [31:0] sel_merge(input logic [31:0] old,
		input logic [31:0] v, input logic [3:0] sel);
		for (int i = 0; i < 4; i++) begin
			sel_merge[i*8 +: 8] = sel[i] ? v[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction : sel_merge

	assign wb_req   = WB_CYC_I && WB_STB_I;
	assign wr_now   = wb_req && WB_WE_I && WB_ACK_O;
	assign exec_go  = wr_now && (WB_ADR_I == `CTA_ADR_CMD);
	assign win_wr   = wr_now && (WB_ADR_I[7:5] == `CTA_GR_PAGE);
	assign mem_done = (state == ST_MEM) && MEM_ACK;

	always_comb begin
		op = cta_op_e'(WB_DAT_I[`CTA_F_OP]);
		sz = cta_size_e'(WB_DAT_I[`CTA_F_SIZE]);
		dst = WB_DAT_I[`CTA_F_DST];
		src = WB_DAT_I[`CTA_F_SRC];
		unique case (WB_DAT_I[`CTA_F_STEP])
			`CTA_STEP_2: stp = `CTA_TWO32;
			`CTA_STEP_4: stp = `CTA_FOUR32;
			default:     stp = `CTA_ONE32;
		endcase
		a = get_op(dst, sz);
		b = WB_DAT_I[`CTA_F_IMM] ? mask_sz(imm, sz) : get_op(src, sz);
		ar = addsub(a, b, 1'b0, 1'b0, sz);
		next_ok = WB_DAT_I[`CTA_F_SIZE] != `CTA_SZ_BAD;
		next_wr = 1'b0;
		next_wsz = sz;
		next_widx = dst;
		next_val = `CTA_ZERO32;
		next_ccr = condition_flags_register;
		next_mem = 1'b0;
		next_mwe = 1'b0;
		next_maddr = `CTA_ZERO32;
		next_mdata = `CTA_ZERO32;
		next_pop = 1'b0;
		adj = `CTA_ZERO8;
		prod8 = 16'h0000;
		prod16 = `CTA_ZERO32;
		unique case (op)
			OP_MOV: begin
				next_wr = 1'b1;
				next_val = b;
			end
			OP_MOV_LD: begin
				next_mem = 1'b1;
				next_maddr = gr[src[2:0]];
			end
			OP_MOV_ST: begin
				next_mem = 1'b1;
				next_mwe = 1'b1;
				next_maddr = gr[dst[2:0]];
				next_mdata = get_op(src, sz);
			end
			OP_POP: begin
				next_ok = next_ok && (sz != SZ_BYTE);
				next_mem = 1'b1;
				next_pop = 1'b1;
				next_maddr = gr[`CTA_SP_IDX];
			end
			OP_PUSH: begin
				next_ok = next_ok && (sz != SZ_BYTE);
				next_mem = 1'b1;
				next_mwe = 1'b1;
				next_maddr = gr[`CTA_SP_IDX] - size_bytes(sz);
				next_mdata = get_op(src, sz);
				next_wr = 1'b1;
				next_wsz = SZ_LONG;
				next_widx = {1'b0, `CTA_SP_IDX};
				next_val = next_maddr;
			end
			OP_ADD, OP_SUB: begin
				next_ok = next_ok && !(op == OP_SUB && sz == SZ_BYTE
					&& WB_DAT_I[`CTA_F_IMM]);
				ar = addsub(a, b, 1'b0, op == OP_SUB, sz);
				next_wr = 1'b1;
				next_val = ar[31:0];
				next_ccr = ar[35:32];
			end
			OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW: begin
				next_ok = next_ok && (sz == SZ_BYTE);
				ar = addsub(a, b, condition_flags_register[`CTA_FL_C],
					op == OP_SUBTRACT_WITH_BORROW, sz);
				next_wr = 1'b1;
				next_val = ar[31:0];
				next_ccr = ar[35:32];
			end
			OP_INC, OP_DEC: begin
				next_ok = next_ok && (stp != `CTA_FOUR32)
					&& !(sz == SZ_BYTE && stp == `CTA_TWO32);
				ar = addsub(a, stp, 1'b0, op == OP_DEC, sz);
				next_wr = 1'b1;
				next_val = ar[31:0];
				next_ccr = {ar[35:33], condition_flags_register[`CTA_FL_C]};
			end
			OP_ADD_SMALL_CONST_LONG, OP_SUB_SMALL_CONST_LONG: begin
				next_ok = next_ok && (sz == SZ_LONG)
					&& (WB_DAT_I[`CTA_F_STEP] != `CTA_STEP_BAD);
				next_wr = 1'b1;
				next_val = (op == OP_SUB_SMALL_CONST_LONG) ? a - stp
					: a + stp;
			end
			OP_DECIMAL_ADJUST_ADD, OP_DECIMAL_ADJUST_SUB: begin
				next_ok = next_ok && (sz == SZ_BYTE);
				// Lacking a half-carry, the low digit is judged by range
				adj = ((condition_flags_register[`CTA_FL_C] || (op == OP_DECIMAL_ADJUST_ADD
					&& a[7:0] > `CTA_BCD_MAX)) ? `CTA_ADJ_HI : `CTA_ZERO8)
					| ((a[3:0] > `CTA_BCD_DIG) ? `CTA_ADJ_LO
					: `CTA_ZERO8);
				ar = addsub(a, {24'h000000, adj}, 1'b0,
					op == OP_DECIMAL_ADJUST_SUB, sz);
				next_wr = 1'b1;
				next_val = ar[31:0];
				next_ccr = {ar[35:34], condition_flags_register[`CTA_FL_V],
					adj[5] | condition_flags_register[`CTA_FL_C]};
			end
			OP_UNSIGNED_MULTIPLY, OP_SIGNED_MULTIPLY: begin
				next_ok = next_ok && (sz != SZ_LONG);
				a = gr[dst[2:0]];
				if (op == OP_SIGNED_MULTIPLY) begin
					prod8 = 16'($signed(a[7:0]) * $signed(b[7:0]));
					prod16 = 32'($signed(a[15:0]) * $signed(b[15:0]));
				end else begin
					prod8 = {8'h00, a[7:0]} * {8'h00, b[7:0]};
					prod16 = {16'h0000, a[15:0]}
						* {16'h0000, b[15:0]};
				end
				next_wr = 1'b1;
				next_widx = {1'b0, dst[2:0]};
				next_wsz = (sz == SZ_BYTE) ? SZ_WORD : SZ_LONG;
				next_val = (sz == SZ_BYTE) ? {16'h0000, prod8} : prod16;
			end
			OP_MOVE_FROM_PERIPHERAL_SYNC, OP_MOVE_TO_PERIPHERAL_SYNC:
				next_ok = 1'b0;
			default:
				next_ok = 1'b0;
		endcase
		if (!next_ok) begin
			next_wr = 1'b0;
			next_mem = 1'b0;
			next_ccr = condition_flags_register;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			for (int i = 0; i < 8; i++) begin
				gr[i] <= `CTA_ZERO32;
			end
		end else if (exec_go && next_wr) begin
			gr[next_widx[2:0]] <= put_op(gr[next_widx[2:0]], next_widx,
				next_wsz, next_val);
		end else if (win_wr) begin
			gr[WB_ADR_I[4:2]] <= sel_merge(gr[WB_ADR_I[4:2]], WB_DAT_I,
				WB_SEL_I);
		end else if (mem_done && !MEM_WE) begin
			// A pop into the stack pointer keeps the loaded value
			if (pend_pop) begin
				gr[`CTA_SP_IDX] <= gr[`CTA_SP_IDX]
					+ size_bytes(pend_sz);
			end
			gr[pend_dst[2:0]] <= put_op(gr[pend_dst[2:0]], pend_dst,
				pend_sz, mask_sz(MEM_RDATA, pend_sz));
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			condition_flags_register <= 4'h0;
			imm <= `CTA_ZERO32;
			stat_ill <= 1'b0;
		end else if (exec_go) begin
			condition_flags_register <= next_ccr;
			stat_ill <= !next_ok;
		end else if (wr_now && WB_ADR_I == `CTA_ADR_CCR && WB_SEL_I[0]) begin
			condition_flags_register <= WB_DAT_I[3:0];
		end else if (wr_now && WB_ADR_I == `CTA_ADR_IMM) begin
			imm <= sel_merge(imm, WB_DAT_I, WB_SEL_I);
		end
	end

	// Memory side holds each request until the access path answers
	always_ff @(posedge CLK) begin
		if (RESET) begin
			state <= ST_IDLE;
			MEM_REQ <= 1'b0;
			MEM_WE <= 1'b0;
			MEM_SIZE <= 2'h0;
			MEM_ADDR <= `CTA_ZERO32;
			MEM_WDATA <= `CTA_ZERO32;
			pend_dst <= 4'h0;
			pend_sz <= SZ_BYTE;
			pend_pop <= 1'b0;
		end else if (exec_go && next_mem) begin
			state <= ST_MEM;
			MEM_REQ <= 1'b1;
			MEM_WE <= next_mwe;
			MEM_SIZE <= sz;
			MEM_ADDR <= next_maddr;
			MEM_WDATA <= next_mdata;
			pend_dst <= dst;
			pend_sz <= sz;
			pend_pop <= next_pop;
		end else if (mem_done) begin
			state <= ST_IDLE;
			MEM_REQ <= 1'b0;
		end
	end

	// Commands stall while memory is busy, so ack waits for idle
	always_ff @(posedge CLK) begin
		if (RESET) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= `CTA_ZERO32;
		end else begin
			WB_ACK_O <= wb_req && !WB_ACK_O && state == ST_IDLE;
			if (WB_ADR_I[7:5] == `CTA_GR_PAGE) begin
				WB_DAT_O <= gr[WB_ADR_I[4:2]];
			end else if (WB_ADR_I == `CTA_ADR_IMM) begin
				WB_DAT_O <= imm;
			end else if (WB_ADR_I == `CTA_ADR_CCR) begin
				WB_DAT_O <= {28'h0000000, condition_flags_register};
			end else if (WB_ADR_I == `CTA_ADR_STAT) begin
				WB_DAT_O <= {30'h0, state == ST_MEM, stat_ill};
			end else begin
				WB_DAT_O <= `CTA_ZERO32;
			end
		end
	end

	logic        exec_q;
	logic        ok_q;
	logic [31:0] cmd_q;
	logic [31:0] a_q;
	logic [31:0] b_q;
	always_ff @(posedge CLK) begin
		exec_q <= !RESET && exec_go;
		ok_q <= next_ok;
		cmd_q <= WB_DAT_I;
		a_q <= a;
		b_q <= b;
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	sequence pop_done_s;
		mem_done && pend_pop && pend_dst[2:0] != `CTA_SP_IDX;
	endsequence
	sequence exec_op_s(cta_op_e o);
		exec_q && ok_q && cta_op_e'(cmd_q[`CTA_F_OP]) == o;
	endsequence

	ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held longer than one cycle");
	mem_hold_a: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ
		&& $stable(MEM_ADDR) && $stable(MEM_WE))
		else $error("memory request dropped before answer");
	peri_refuse_a: assert property (exec_go && (op ==
		OP_MOVE_FROM_PERIPHERAL_SYNC || op == OP_MOVE_TO_PERIPHERAL_SYNC)
		|=> stat_ill && state == ST_IDLE && $stable(condition_flags_register))
		else $error("peripheral sync move was executed");
	pop_sp_step_a: assert property (pop_done_s |=>
		gr[`CTA_SP_IDX] == $past(gr[`CTA_SP_IDX])
		+ size_bytes($past(pend_sz)))
		else $error("pop did not advance stack pointer");
	push_predec_a: assert property (exec_go && op == OP_PUSH
		&& next_ok |=> MEM_REQ && MEM_WE
		&& MEM_ADDR == gr[`CTA_SP_IDX]
		&& MEM_ADDR == $past(gr[`CTA_SP_IDX]) - size_bytes($past(sz)))
		else $error("push address not pre-decremented");
	sub_imm_refuse_a: assert property (exec_go && op == OP_SUB
		&& sz == SZ_BYTE && WB_DAT_I[`CTA_F_IMM] |=> stat_ill)
		else $error("byte immediate subtract accepted");
	carry_add_a: assert property (exec_op_s(OP_ADD_WITH_CARRY) |->
		gr[cmd_q[10:8]][7:0] == a_q[7:0] + b_q[7:0]
		+ {7'h00, $past(condition_flags_register[`CTA_FL_C])} || cmd_q[`CTA_F_DST] !=
		{1'b1, cmd_q[10:8]})
		else $error("carry add result wrong");
	long_step_a: assert property (
		exec_op_s(OP_ADD_SMALL_CONST_LONG)
		&& cmd_q[`CTA_F_STEP] == `CTA_STEP_4 |->
		gr[cmd_q[10:8]] == a_q + `CTA_FOUR32)
		else $error("long add of four wrong");
	mul_byte_a: assert property (exec_op_s(OP_UNSIGNED_MULTIPLY)
		&& cmd_q[`CTA_F_SIZE] == SZ_BYTE |->
		gr[cmd_q[10:8]][15:0] == a_q[7:0] * b_q[7:0])
		else $error("unsigned byte product wrong");
	zero_flag_a: assert property (exec_op_s(OP_ADD) |->
		condition_flags_register[`CTA_FL_Z] == (get_op(cmd_q[`CTA_F_DST],
		cta_size_e'(cmd_q[`CTA_F_SIZE])) == `CTA_ZERO32))
		else $error("zero flag disagrees with result");
endmodule : cta_datapath

// ===== cta_defines.svh
// Offsets, field positions and constants of the transfer/arithmetic datapath
`ifndef CTA_DEFINES_SVH
`define CTA_DEFINES_SVH
`define CTA_ADR_CMD   8'h00
`define CTA_ADR_IMM   8'h04
`define CTA_ADR_CCR   8'h08
`define CTA_ADR_STAT  8'h0C
`define CTA_GR_PAGE   3'h1
`define CTA_F_OP      4:0
`define CTA_F_IMM     5
`define CTA_F_SIZE    7:6
`define CTA_F_DST     11:8
`define CTA_F_SRC     15:12
`define CTA_F_STEP    17:16
`define CTA_SZ_BAD    2'h3
`define CTA_STEP_2    2'h1
`define CTA_STEP_4    2'h2
`define CTA_STEP_BAD  2'h3
`define CTA_FL_N      3
`define CTA_FL_Z      2
`define CTA_FL_V      1
`define CTA_FL_C      0
`define CTA_ST_ILL    0
`define CTA_ST_BUSY   1
`define CTA_SP_IDX    3'h7
`define CTA_ZERO32    32'h0000_0000
`define CTA_ONE32     32'h0000_0001
`define CTA_TWO32     32'h0000_0002
`define CTA_FOUR32    32'h0000_0004
`define CTA_BCD_DIG   4'h9
`define CTA_BCD_MAX   8'h99
`define CTA_ADJ_LO    8'h06
`define CTA_ADJ_HI    8'h60
`define CTA_ZERO8     8'h00
`endif

// ===== cta_pkg.sv
// Types shared by the transfer/arithmetic datapath
package cta_pkg;
	typedef enum logic [4:0] {
		OP_MOV, OP_MOV_LD, OP_MOV_ST, OP_POP, OP_PUSH,
		OP_ADD, OP_SUB, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW,
		OP_INC, OP_DEC, OP_ADD_SMALL_CONST_LONG, OP_SUB_SMALL_CONST_LONG,
		OP_DECIMAL_ADJUST_ADD, OP_DECIMAL_ADJUST_SUB,
		OP_UNSIGNED_MULTIPLY, OP_SIGNED_MULTIPLY,
		OP_MOVE_FROM_PERIPHERAL_SYNC, OP_MOVE_TO_PERIPHERAL_SYNC
	} cta_op_e;
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} cta_size_e;
	typedef enum logic {ST_IDLE, ST_MEM} cta_state_e;
endpackage : cta_pkg

// ===== cta_mem_model.sv
// Memory access partner: byte memory answering after a varying delay
`timescale 1ns/1ns
module cta_mem_model (
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic        MEM_REQ,
	input  wire logic        MEM_WE,
	input  wire logic [1:0]  MEM_SIZE,
	input  wire logic [31:0] MEM_ADDR,
	input  wire logic [31:0] MEM_WDATA,
	output logic      [31:0] MEM_RDATA,
	output logic             MEM_ACK
);
	logic [7:0] m [256];
	logic [1:0] dly;
	logic [1:0] slow;
	int         nb;
	// Delay cycles 0..3 so that prompt and slow answers both occur
	always @(posedge CLK) begin
		nb = 1 << MEM_SIZE;
		if (RESET) begin
			MEM_ACK   <= 1'b0;
			MEM_RDATA <= 32'h0;
			dly       <= 2'h0;
			slow      <= 2'h0;
		end else if (MEM_REQ && !MEM_ACK && dly == 2'h0) begin
			MEM_ACK   <= 1'b1;
			MEM_RDATA <= 32'h0;
			// Big-endian: the lowest address holds the top byte
			for (int i = 0; i < nb; i++) begin
				if (MEM_WE)
					m[8'(MEM_ADDR[7:0] + i)] <= MEM_WDATA[8*(nb-1-i) +: 8];
				else
					MEM_RDATA[8*(nb-1-i) +: 8] <= m[8'(MEM_ADDR[7:0] + i)];
			end
		end else begin
			MEM_ACK   <= 1'b0;
			// Data outside the answer cycle is not to be relied on
			MEM_RDATA <= ~MEM_RDATA;
			if (MEM_REQ && !MEM_ACK) begin
				dly <= dly - 2'h1;
			end else begin
				dly  <= slow;
				slow <= slow + 2'h1;
			end
		end
	end
endmodule : cta_mem_model

// ===== cta_datapath_tb_top.sv
// Self-checking bench for the transfer/arithmetic datapath
`timescale 1ns/1ns
module cta_datapath_tb_top;
	import cta_pkg::*;
	logic        CLK = 1'b0;
	logic        RESET = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dat = 32'h0, dat_o, maddr, mwdata, mrdata;
	logic [1:0]  msz;
	logic        ack, mreq, mwe, mack;
	int          n_mismatch = 0, compares = 0;
	logic [31:0] exp_q [$];
	logic [31:0] rnd = 32'h19616AF5;
	logic [31:0] v [8];
	logic [31:0] a, b, m;
	logic [35:0] e;
	logic signed [15:0] p16;
	logic signed [31:0] p32;
	int          w;

	cta_datapath dut (.CLK(CLK), .RESET(RESET), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
		.WB_DAT_O(dat_o), .WB_ACK_O(ack), .MEM_REQ(mreq), .MEM_WE(mwe),
		.MEM_SIZE(msz), .MEM_ADDR(maddr), .MEM_WDATA(mwdata),
		.MEM_RDATA(mrdata), .MEM_ACK(mack));
	cta_mem_model mem (.CLK(CLK), .RESET(RESET), .MEM_REQ(mreq), .MEM_WE(mwe),
		.MEM_SIZE(msz), .MEM_ADDR(maddr), .MEM_WDATA(mwdata),
		.MEM_RDATA(mrdata), .MEM_ACK(mack));

	always #5 CLK = ~CLK;

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	function automatic logic [7:0] ra(input logic [2:0] n);
		return 8'h20 + {3'h0, n, 2'b00};
	endfunction : ra
	// Returns {N, Z, V, C, result} at width wd
	function automatic logic [35:0] arith(input logic [31:0] x, y,
		input logic cin, sub, input int wd);
		logic [32:0] f;
		logic [31:0] mk, r;
		logic        vv;
		mk = (wd == 32) ? 32'hFFFFFFFF : (32'h1 << wd) - 32'h1;
		f = sub ? {1'b0, x & mk} - {1'b0, y & mk} - cin
			: {1'b0, x & mk} + {1'b0, y & mk} + cin;
		r = f[31:0] & mk;
		vv = (sub ? x[wd-1] != y[wd-1] : x[wd-1] == y[wd-1])
			&& r[wd-1] != x[wd-1];
		return {r[wd-1], r == 32'h0, vv, f[wd], r};
	endfunction : arith

	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		compares++;
		if (seen !== expv) begin
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
			n_mismatch++;
		end
	endtask : check
	task automatic give_verdict();
		$display("mismatches=%0d compares=%0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	task automatic bus(input logic wr, input logic [7:0] ad,
		input logic [31:0] d);
		int k;
		@(posedge CLK);
		cyc <= 1'b1; stb <= 1'b1; we <= wr; adr <= ad; sel <= 4'hF; dat <= d;
		k = 0;
		do begin
			@(posedge CLK);
			k++;
		end while (ack !== 1'b1 && k < 200);
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		if (k >= 200) begin
			n_mismatch++;
			give_verdict();
		end
	endtask : bus
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		bus(1'b1, ad, d);
	endtask : wr
	task automatic rd(input logic [7:0] ad, input logic [31:0] ex);
		exp_q.push_back(ex);
		bus(1'b0, ad, 32'h0);
	endtask : rd
	task automatic op(input logic [4:0] o, input logic im,
		input logic [1:0] sz, input logic [3:0] d, s, input logic [1:0] st);
		wr(8'h00, {14'h0, st, s, d, sz, im, o});
	endtask : op
	// Read results are paired with the oldest expectation at the ack edge
	always @(posedge CLK) begin
		if (ack === 1'b1 && we === 1'b0 && cyc === 1'b1) begin
			if (exp_q.size() != 0) check(dat_o, exp_q.pop_front());
			else check(32'h1, 32'h0);
		end
	end
	initial begin
		#500000;
		n_mismatch++;
		give_verdict();
	end

	initial begin
		repeat (4) @(posedge CLK);
		RESET <= 1'b0;
		rd(8'h08, 32'h0);
		rd(8'h0C, 32'h0);
		wr(8'h10, 32'h1234);
		rd(8'h10, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			v[i] = rnd; rnd = lfsr(rnd);
			wr(ra(i), v[i]);
		end
		for (int i = 0; i < 8; i++) rd(ra(i), v[i]);
		op(OP_MOV, 1'b0, SZ_BYTE, 4'h2, 4'h9, 2'h0);
		rd(ra(2), {v[2][31:16], v[1][7:0], v[2][7:0]});
		op(OP_MOV, 1'b0, SZ_WORD, 4'hB, 4'h4, 2'h0);
		rd(ra(3), {v[4][15:0], v[3][15:0]});
		wr(8'h04, 32'hA5A50F0F);
		op(OP_MOV, 1'b1, SZ_LONG, 4'h5, 4'h0, 2'h0);
		wr(ra(6), 32'h40);
		op(OP_MOV_ST, 1'b0, SZ_LONG, 4'h6, 4'h5, 2'h0);
		op(OP_MOV_LD, 1'b0, SZ_LONG, 4'h0, 4'h6, 2'h0);
		rd(ra(0), 32'hA5A50F0F);
		$display("test moves done");
		for (int k = 0; k < 12; k++) begin
			a = (k == 0) ? 32'hFFFFFFFF : rnd; rnd = lfsr(rnd);
			b = (k == 0) ? 32'h1 : rnd; rnd = lfsr(rnd);
			w = (k % 3 == 0) ? 8 : (k % 3 == 1) ? 16 : 32;
			m = (w == 32) ? 32'hFFFFFFFF : (32'h1 << w) - 32'h1;
			wr(ra(1), a);
			if (k < 6) wr(ra(2), b); else wr(8'h04, b);
			op((k / 3) % 2 ? OP_SUB : OP_ADD, k >= 6, 2'(k % 3),
				(w == 8) ? 4'h9 : 4'h1, (w == 8) ? 4'hA : 4'h2, 2'h0);
			e = arith(a, b, 1'b0, (k / 3) % 2, w);
			if (k == 9) begin
				rd(ra(1), a);
				rd(8'h0C, 32'h1);
			end else begin
				rd(ra(1), (a & ~m) | e[31:0]);
				rd(8'h08, {28'h0, e[35:32]});
			end
		end
		$display("test add sub done");
		for (int j = 0; j < 4; j++) begin
			wr(ra(1), v[1]);
			case (j)
				0: op(OP_MOVE_FROM_PERIPHERAL_SYNC, 1'b0, SZ_BYTE, 4'h9, 4'hA, 2'h0);
				1: op(OP_MOVE_TO_PERIPHERAL_SYNC, 1'b0, SZ_BYTE, 4'h9, 4'hA, 2'h0);
				2: op(OP_INC, 1'b0, SZ_BYTE, 4'h9, 4'h0, 2'h1);
				default: op(OP_ADD, 1'b0, 2'h3, 4'h1, 4'h2, 2'h0);
			endcase
			rd(ra(1), v[1]);
			rd(8'h0C, 32'h1);
		end
		$display("test refusals done");
		a = rnd; rnd = lfsr(rnd);
		b = rnd; rnd = lfsr(rnd);
		wr(8'h08, 32'h1);
		wr(ra(1), a);
		wr(ra(2), b);
		op(OP_ADD_WITH_CARRY, 1'b0, SZ_BYTE, 4'h9, 4'hA, 2'h0);
		e = arith(a, b, 1'b1, 1'b0, 8);
		rd(ra(1), {a[31:8], e[7:0]});
		wr(8'h08, 32'h1);
		wr(8'h04, b);
		op(OP_SUBTRACT_WITH_BORROW, 1'b1, SZ_BYTE, 4'h9, 4'h0, 2'h0);
		e = arith({a[31:8], e[7:0]}, b, 1'b1, 1'b1, 8);
		rd(ra(1), {a[31:8], e[7:0]});
		$display("test carry done");
		wr(ra(1), 32'h1234FFFF);
		op(OP_INC, 1'b0, SZ_WORD, 4'h1, 4'h0, 2'h1);
		rd(ra(1), 32'h12340001);
		op(OP_DEC, 1'b0, SZ_LONG, 4'h1, 4'h0, 2'h0);
		rd(ra(1), 32'h12340000);
		op(OP_ADD_SMALL_CONST_LONG, 1'b0, SZ_LONG, 4'h1, 4'h0, 2'h2);
		rd(ra(1), 32'h12340004);
		op(OP_SUB_SMALL_CONST_LONG, 1'b0, SZ_LONG, 4'h1, 4'h0, 2'h1);
		rd(ra(1), 32'h12340002);
		wr(ra(1), 32'h15);
		wr(ra(2), 32'h27);
		op(OP_ADD, 1'b0, SZ_BYTE, 4'h9, 4'hA, 2'h0);
		op(OP_DECIMAL_ADJUST_ADD, 1'b0, SZ_BYTE, 4'h9, 4'h0, 2'h0);
		rd(ra(1), 32'h42);
		wr(ra(2), 32'h15);
		op(OP_SUB, 1'b0, SZ_BYTE, 4'h9, 4'hA, 2'h0);
		op(OP_DECIMAL_ADJUST_SUB, 1'b0, SZ_BYTE, 4'h9, 4'h0, 2'h0);
		rd(ra(1), 32'h27);
		$display("test steps done");
		for (int k = 0; k < 4; k++) begin
			a = rnd | 32'h8080; rnd = lfsr(rnd);
			b = rnd; rnd = lfsr(rnd);
			wr(ra(1), a);
			wr(ra(2), b);
			op(k < 2 ? OP_UNSIGNED_MULTIPLY : OP_SIGNED_MULTIPLY, 1'b0,
				2'(k % 2), 4'h1, (k % 2) ? 4'h2 : 4'hA, 2'h0);
			if (k < 2) begin
				p16 = {8'h0, a[7:0]} * {8'h0, b[7:0]};
				p32 = {16'h0, a[15:0]} * {16'h0, b[15:0]};
			end else begin
				p16 = $signed(a[7:0]) * $signed(b[7:0]);
				p32 = $signed(a[15:0]) * $signed(b[15:0]);
			end
			rd(ra(1), (k % 2) ? p32 : {a[31:16], p16});
		end
		$display("test multiply done");
		wr(ra(7), 32'h100);
		op(OP_PUSH, 1'b0, SZ_LONG, 4'h3, 4'h3, 2'h0);
		rd(ra(7), 32'hFC);
		op(OP_PUSH, 1'b0, SZ_WORD, 4'h4, 4'h4, 2'h0);
		rd(ra(7), 32'hFA);
		op(OP_POP, 1'b0, SZ_WORD, 4'h5, 4'h5, 2'h0);
		rd(ra(5), {16'hA5A5, v[4][15:0]});
		rd(ra(7), 32'hFC);
		op(OP_POP, 1'b0, SZ_LONG, 4'h6, 4'h6, 2'h0);
		rd(ra(6), {v[4][15:0], v[3][15:0]});
		rd(ra(7), 32'h100);
		wr(ra(2), 32'hFC);
		op(OP_MOV_LD, 1'b0, SZ_LONG, 4'h1, 4'h2, 2'h0);
		rd(ra(1), {v[4][15:0], v[3][15:0]});
		$display("test stack done");
		give_verdict();
	end
endmodule : cta_datapath_tb_top
